// *** src/rch_defines.svh ***
// constants for the remote command handshake block
//
// How it works
// - ram write copies setpoint, then raises done
// - while ram command held, setpoint tracks continuously
// - persistent write stores ram and eeprom, then done
// - vector modes also store torque command or limit
// - exec request runs six instruction words, then done
// - simultaneous requests with param zero run only one
// - error reset during fault resets, clears error flag
// - net inputs three to five drive assigned functions
// - input function params reselect assignable bit functions
// - command source params can block the network reset function
// - fixed bits keep dedicated function, never remapped
// - no torque control with permanent magnet motor
`ifndef RCH_DEFINES_SVH
`define RCH_DEFINES_SVH

// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define RCH_WORD_W 16
`define RCH_FUNC_W 8
`define RCH_INSTR_N 6
`define RCH_ASSIGN_N 10
`define RCH_NET_FIRST 7
`define RCH_FUNC_RESET 8'h0a
`define RCH_FUNC_NONE 8'hff
`define RCH_EEPROM_TIME_NS 1000
`define RCH_EEPROM_CYCLES ((`RCH_EEPROM_TIME_NS + 3) / 4)
`define RCH_RESET_TIME_NS 400
`define RCH_RESET_CYCLES ((`RCH_RESET_TIME_NS + 3) / 4)

`endif

// *** src/rch_pkg.sv ***
// types for the remote command handshake block
package rch_pkg;
    typedef enum logic [4:0] {
        RCH_IDLE = 5'b00001,
        RCH_RAM = 5'b00010,
        RCH_EEP = 5'b00100,
        RCH_EXEC = 5'b01000,
        RCH_HOLD = 5'b10000
    } rch_state_e;
    typedef enum logic [1:0] {
        RCH_SPEED_CTRL = 2'h0,
        RCH_TORQUE_CTRL = 2'h1,
        RCH_VF_CTRL = 2'h2
    } rch_ctrl_mode_e;
endpackage : rch_pkg

// *** src/rch_command_handshake.sv ***
// remote command handshake: setpoint writes, instruction exec, error reset, net inputs
`include "rch_defines.svh"
module rch_command_handshake
    import rch_pkg::*;
#(
    parameter int WORD_W = `RCH_WORD_W,
    parameter int FUNC_W = `RCH_FUNC_W,
    parameter int ASSIGN_N = `RCH_ASSIGN_N,
    parameter int EEPROM_CYCLES = `RCH_EEPROM_CYCLES,
    parameter int RESET_CYCLES = `RCH_RESET_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_setpoint_ram_write_cmd,
    input wire logic i_setpoint_persistent_write_cmd,
    input wire logic i_instruction_exec_request,
    input wire logic i_error_reset_request,
    input wire logic i_net_input_three,
    input wire logic i_net_input_four,
    input wire logic i_net_input_five,
    input wire logic [WORD_W-1:0] i_setpoint_word,
    input wire logic [WORD_W-1:0] i_second_word,
    input wire logic [6*WORD_W-1:0] i_instr_words,
    input wire logic [ASSIGN_N*FUNC_W-1:0] i_input_function_params,
    input wire logic i_command_source_param,
    input wire logic i_speed_command_source_param,
    input wire logic i_simultaneous_exec_param,
    input wire logic i_sensorless_vector,
    input wire logic [1:0] i_ctrl_mode,
    input wire logic i_pm_motor,
    input wire logic i_drive_fault,
    output logic o_setpoint_ram_write_done,
    output logic o_setpoint_persistent_write_done,
    output logic o_instruction_exec_done,
    output logic o_error_status_flag,
    output logic [WORD_W-1:0] o_ram_setpoint,
    output logic [WORD_W-1:0] o_ram_torque_cmd,
    output logic [WORD_W-1:0] o_ram_torque_limit,
    output logic o_eeprom_write,
    output logic [WORD_W-1:0] o_eeprom_setpoint,
    output logic [WORD_W-1:0] o_eeprom_second,
    output logic o_instr_exec,
    output logic [6*WORD_W-1:0] o_instr_words,
    output logic o_drive_reset,
    output logic [2:0] o_net_func_active,
    output logic [3*FUNC_W-1:0] o_net_func_code
);

    // ------------------------------------------------------------
    // input synchronisers (commands arrive from the link)
    // ------------------------------------------------------------
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
        end else begin
            sync1_r <= {i_net_input_five, i_net_input_four, i_net_input_three,
                i_error_reset_request, i_instruction_exec_request,
                i_setpoint_persistent_write_cmd, i_setpoint_ram_write_cmd};
            sync2_r <= sync1_r;
        end
    end
    logic ram_cmd, eep_cmd, exe_cmd, err_cmd;
    assign ram_cmd = sync2_r[0];
    assign eep_cmd = sync2_r[1];
    assign exe_cmd = sync2_r[2];
    assign err_cmd = sync2_r[3];

    // ------------------------------------------------------------
    // mode helpers
    // ------------------------------------------------------------
    function automatic logic torque_mode_f(input logic [1:0] mode, input logic pm);
        torque_mode_f = (mode == 2'(RCH_TORQUE_CTRL)) && !pm;
    endfunction : torque_mode_f

    logic torque_sel, speed_sel;
    assign torque_sel = i_sensorless_vector && torque_mode_f(i_ctrl_mode, i_pm_motor);
    assign speed_sel = i_sensorless_vector && (i_ctrl_mode == 2'(RCH_SPEED_CTRL));

    // ------------------------------------------------------------
    // request arbiter and sequencer
    // ------------------------------------------------------------
    rch_state_e state_r;
    rch_state_e state_nxt;
    logic [15:0] count_r;
    logic ram_pend, eep_pend, exe_pend;
    assign ram_pend = ram_cmd && !o_setpoint_ram_write_done;
    assign eep_pend = eep_cmd && !o_setpoint_persistent_write_done;
    assign exe_pend = exe_cmd && !o_instruction_exec_done;

    // one request per pass; with simultaneous param zero the others are dropped
    logic [2:0] grant;
    logic [2:0] drop;
    always_comb begin
        grant = 3'h0;
        if (ram_pend) begin
            grant = 3'h1;
        end else if (eep_pend) begin
            grant = 3'h2;
        end else if (exe_pend) begin
            grant = 3'h4;
        end
        drop = i_simultaneous_exec_param ? 3'h0 : ({exe_pend, eep_pend, ram_pend} & ~grant);
    end

    logic [2:0] dropped_r;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dropped_r <= 3'h0;
        end else if (state_r == RCH_IDLE && grant != 3'h0) begin
            dropped_r <= dropped_r | drop;
        end else begin
            dropped_r <= dropped_r & {exe_cmd, eep_cmd, ram_cmd};
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RCH_IDLE: begin
                if (grant[0] && !dropped_r[0]) begin
                    state_nxt = RCH_RAM;
                end else if (grant[1] && !dropped_r[1]) begin
                    state_nxt = RCH_EEP;
                end else if (grant[2] && !dropped_r[2]) begin
                    state_nxt = RCH_EXEC;
                end
            end
            RCH_RAM: state_nxt = RCH_IDLE;
            RCH_EEP: begin
                if (count_r == 16'(EEPROM_CYCLES - 1)) begin
                    state_nxt = RCH_IDLE;
                end
            end
            RCH_EXEC: state_nxt = RCH_IDLE;
            RCH_HOLD: state_nxt = RCH_IDLE;
            default: state_nxt = RCH_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= RCH_IDLE;
            count_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            count_r <= (state_r == RCH_EEP) ? count_r + 16'h0001 : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // memory writes and instruction execution
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ram_setpoint <= '0;
            o_ram_torque_cmd <= '0;
            o_ram_torque_limit <= '0;
        end else if (state_r == RCH_RAM || state_r == RCH_EEP
                || (ram_cmd && o_setpoint_ram_write_done)) begin
            o_ram_setpoint <= i_setpoint_word;
            if (torque_sel) begin
                o_ram_torque_cmd <= i_second_word;
            end
            if (speed_sel) begin
                o_ram_torque_limit <= i_second_word;
            end
        end
    end

    // eeprom is slow: the word is latched at entry and held for the write time
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_eeprom_write <= 1'b0;
            o_eeprom_setpoint <= '0;
            o_eeprom_second <= '0;
        end else begin
            o_eeprom_write <= (state_nxt == RCH_EEP);
            if (state_r == RCH_IDLE && state_nxt == RCH_EEP) begin
                o_eeprom_setpoint <= i_setpoint_word;
                o_eeprom_second <= (torque_sel || speed_sel) ? i_second_word : '0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_instr_exec <= 1'b0;
            o_instr_words <= '0;
        end else begin
            o_instr_exec <= (state_r == RCH_EXEC);
            if (state_r == RCH_EXEC) begin
                o_instr_words <= i_instr_words;
            end
        end
    end

    // ------------------------------------------------------------
    // completion flags
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_setpoint_ram_write_done <= 1'b0;
            o_setpoint_persistent_write_done <= 1'b0;
            o_instruction_exec_done <= 1'b0;
        end else begin
            // set wins over the clear when both fall in one cycle
            if (state_r == RCH_RAM) begin
                o_setpoint_ram_write_done <= 1'b1;
            end else if (!ram_cmd) begin
                o_setpoint_ram_write_done <= 1'b0;
            end
            if (state_r == RCH_EEP && state_nxt == RCH_IDLE) begin
                o_setpoint_persistent_write_done <= 1'b1;
            end else if (!eep_cmd) begin
                o_setpoint_persistent_write_done <= 1'b0;
            end
            if (state_r == RCH_EXEC) begin
                o_instruction_exec_done <= 1'b1;
            end else if (!exe_cmd) begin
                o_instruction_exec_done <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // network input mapping and error reset
    // ------------------------------------------------------------
    logic net_reset;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_net
            logic [FUNC_W-1:0] code;
            logic blocked;
            assign code = i_input_function_params[(`RCH_NET_FIRST+g)*FUNC_W +: FUNC_W];
            // reset function refused from network under the source params
            assign blocked = (code == FUNC_W'(`RCH_FUNC_RESET))
                && (i_command_source_param || i_speed_command_source_param);
            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    o_net_func_active[g] <= 1'b0;
                    o_net_func_code[g*FUNC_W +: FUNC_W] <= FUNC_W'(`RCH_FUNC_NONE);
                end else begin
                    o_net_func_active[g] <= sync2_r[4+g] && !blocked;
                    o_net_func_code[g*FUNC_W +: FUNC_W] <= code;
                end
            end
        end
    endgenerate
    // fixed bits (error reset, command bits) bypass the assignment table
    assign net_reset = err_cmd;

    logic [15:0] rst_cnt_r;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_drive_reset <= 1'b0;
            rst_cnt_r <= 16'h0000;
            o_error_status_flag <= 1'b0;
        end else begin
            if (!o_drive_reset && net_reset && i_drive_fault) begin
                o_drive_reset <= 1'b1;
                rst_cnt_r <= 16'h0000;
            end else if (o_drive_reset) begin
                rst_cnt_r <= rst_cnt_r + 16'h0001;
                if (rst_cnt_r == 16'(RESET_CYCLES - 1)) begin
                    o_drive_reset <= 1'b0;
                end
            end
            // fault raising is held off while o_drive_reset is high, so the clear at the end of the pulse applies
            if (i_drive_fault && !o_drive_reset) begin
                o_error_status_flag <= 1'b1;
            end else if (o_drive_reset && rst_cnt_r == 16'(RESET_CYCLES - 1)) begin
                o_error_status_flag <= 1'b0;
            end
        end
    end

endmodule : rch_command_handshake

// *** testbench/rch_asserts.sv ***
// assertion checker for the remote command handshake
module rch_asserts #(parameter int WORD_W = 16) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_setpoint_ram_write_cmd,
    input wire logic i_simultaneous_exec_param,
    input wire logic i_pm_motor,
    input wire logic [WORD_W-1:0] i_setpoint_word,
    input wire logic o_setpoint_ram_write_done,
    input wire logic o_setpoint_persistent_write_done,
    input wire logic o_instruction_exec_done,
    input wire logic o_error_status_flag,
    input wire logic o_instr_exec,
    input wire logic o_drive_reset,
    input wire logic [WORD_W-1:0] o_ram_setpoint,
    input wire logic [WORD_W-1:0] o_ram_torque_cmd,
    input wire logic [WORD_W-1:0] o_eeprom_setpoint
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    ram_done_a: assert property (
        $rose(o_setpoint_ram_write_done) |-> $past(i_setpoint_ram_write_cmd, 2)
        && o_ram_setpoint == $past(i_setpoint_word)) else $error("ram done unasked");
    ram_track_a: assert property (
        ($stable(i_setpoint_word) && o_setpoint_ram_write_done && i_setpoint_ram_write_cmd) [*4]
        |-> o_ram_setpoint == i_setpoint_word) else $error("setpoint not tracked");
    done_clear_a: assert property (
        $fell(i_setpoint_ram_write_cmd) |-> ##[1:5] !o_setpoint_ram_write_done) else $error("done stuck");
    eep_both_a: assert property (
        $rose(o_setpoint_persistent_write_done) |-> o_eeprom_setpoint == o_ram_setpoint)
        else $error("ram and eeprom differ");
    exec_pulse_a: assert property (
        $rose(o_instruction_exec_done) |-> o_instr_exec ##1 !o_instr_exec) else $error("exec pulse bad");
    one_grant_a: assert property (
        !i_simultaneous_exec_param |-> $onehot0({o_setpoint_ram_write_done,
        o_setpoint_persistent_write_done, o_instruction_exec_done})) else $error("two grants");
    reset_pulse_a: assert property (
        $rose(o_drive_reset) |-> o_error_status_flag ##1 o_drive_reset [*3]) else $error("reset pulse");
    pm_hold_a: assert property (
        i_pm_motor && $past(i_pm_motor) |-> $stable(o_ram_torque_cmd)) else $error("torque with pm");
    cover property ($rose(o_setpoint_persistent_write_done));
    cover property ($rose(o_drive_reset));
    cover property (!i_simultaneous_exec_param && $rose(o_setpoint_ram_write_done));
    cover property (i_simultaneous_exec_param && $rose(o_instruction_exec_done));
endmodule : rch_asserts

bind rch_command_handshake rch_asserts #(.WORD_W(WORD_W)) chk_u (.*);

// *** testbench/rch_master_model.sv ***
// master station model: raises command bits, waits for done, lowers them
module rch_master_model (
    input wire logic i_clock,
    input wire logic [2:0] i_done,
    output logic [2:0] o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_cmd = 3'h0;
    // held until done shows; holding keeps the ram setpoint live
    task automatic request(input logic [2:0] m, output logic [2:0] seen);
        int n;
        @(posedge i_clock);
        #1 o_cmd = m;
        n = 0;
        while ((i_done & m) == 3'h0 && n < 40) begin
            @(posedge i_clock);
            n++;
        end
        repeat (4) @(posedge i_clock);
        #1 seen = i_done;
    endtask : request
    // lower after done, then wait for done to clear before reuse
    task automatic drop_cmds();
        int n;
        @(posedge i_clock);
        #1 o_cmd = 3'h0;
        n = 0;
        while (i_done != 3'h0 && n < 20) begin
            @(posedge i_clock);
            n++;
        end
        #1;
    endtask : drop_cmds
endmodule : rch_master_model

// *** testbench/rch_command_handshake_tb.sv ***
// self-checking bench for the remote command handshake
`define CHK(nm, exp, got) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
end
module rch_command_handshake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    wire logic i_setpoint_ram_write_cmd, i_setpoint_persistent_write_cmd, i_instruction_exec_request;
    logic i_error_reset_request, i_net_input_three, i_net_input_four, i_net_input_five;
    logic i_command_source_param, i_speed_command_source_param, i_simultaneous_exec_param;
    logic i_sensorless_vector, i_pm_motor, i_drive_fault, o_eeprom_write, o_instr_exec;
    logic o_setpoint_ram_write_done, o_setpoint_persistent_write_done, o_instruction_exec_done;
    logic o_error_status_flag, o_drive_reset;
    logic [1:0] i_ctrl_mode;
    logic [15:0] i_setpoint_word, i_second_word, o_ram_setpoint, o_ram_torque_cmd;
    logic [15:0] o_ram_torque_limit, o_eeprom_setpoint, o_eeprom_second;
    logic [95:0] i_instr_words, o_instr_words;
    logic [79:0] i_input_function_params;
    logic [2:0] o_net_func_active, seen;
    logic [23:0] o_net_func_code;
    int err_count = 0;
    int n_compared = 0;
    int n;
    wire logic [2:0] dones = {o_instruction_exec_done, o_setpoint_persistent_write_done,
        o_setpoint_ram_write_done};
    rch_command_handshake #(.EEPROM_CYCLES(4), .RESET_CYCLES(4)) dut_u (.*);
    rch_master_model m_u (
        .i_clock(i_clock),
        .i_done(dones),
        .o_cmd({i_instruction_exec_request, i_setpoint_persistent_write_cmd,
            i_setpoint_ram_write_cmd})
    );
    initial begin
        forever #2 i_clock = ~i_clock;
    end
    task automatic step(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask : step
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    // whole run is under 200 cycles; the 40us limit (10000 cycles) means a hang
    initial begin
        #40us;
        err_count++;
        end_sim();
    end
    initial begin
        {i_error_reset_request, i_net_input_three, i_net_input_four, i_net_input_five} = 4'h0;
        {i_command_source_param, i_speed_command_source_param, i_simultaneous_exec_param} = 3'h0;
        {i_sensorless_vector, i_pm_motor, i_drive_fault, i_ctrl_mode} = 5'h00;
        {i_setpoint_word, i_second_word} = {16'h1234, 16'h00aa};
        i_instr_words = 96'h0c0b0a09_08070605_04030201;
        i_input_function_params = {8'h11, 8'h22, 8'h33, 56'h0};
        step(12);
        i_reset_n = 1'b1;
        `CHK("func_code", 24'hffffff, o_net_func_code)
        m_u.request(3'h1, seen);
        `CHK("ram_sp", 16'h1234, o_ram_setpoint)
        `CHK("ram_done", 3'h1, seen)
        i_setpoint_word = 16'h5678;
        step(3);
        `CHK("ram_track", 16'h5678, o_ram_setpoint)
        m_u.drop_cmds();
        `CHK("done_clr", 3'h0, dones)
        {i_sensorless_vector, i_ctrl_mode, i_setpoint_word} = {3'h4, 16'h9abc};
        m_u.request(3'h2, seen);
        `CHK("eep_sp", 16'h9abc, o_eeprom_setpoint)
        `CHK("eep_done", 3'h2, seen)
        `CHK("eep_wr_end", 1'b0, o_eeprom_write)
        `CHK("eep_ram", 16'h9abc, o_ram_setpoint)
        `CHK("eep_second", 16'h00aa, o_eeprom_second)
        `CHK("trq_limit", 16'h00aa, o_ram_torque_limit)
        m_u.drop_cmds();
        {i_ctrl_mode, i_pm_motor, i_second_word} = {2'h1, 1'b1, 16'h00bb};
        m_u.request(3'h1, seen);
        `CHK("trq_cmd_pm", 16'h0000, o_ram_torque_cmd)
        m_u.drop_cmds();
        i_pm_motor = 1'b0;
        m_u.request(3'h1, seen);
        `CHK("trq_cmd", 16'h00bb, o_ram_torque_cmd)
        m_u.drop_cmds();
        m_u.request(3'h4, seen);
        `CHK("exec_done", 3'h4, seen)
        `CHK("instr", i_instr_words, o_instr_words)
        m_u.drop_cmds();
        m_u.request(3'h7, seen);
        `CHK("one_grant", 3'h1, seen)
        m_u.drop_cmds();
        // with the parameter set, all three run one after another
        i_simultaneous_exec_param = 1'b1;
        m_u.request(3'h7, seen);
        step(12);
        `CHK("all_run", 3'h7, dones)
        m_u.drop_cmds();
        `CHK("all_clr", 3'h0, dones)
        i_simultaneous_exec_param = 1'b0;
        i_drive_fault = 1'b1;
        step(8);
        `CHK("err_flag", 1'b1, o_error_status_flag)
        i_error_reset_request = 1'b1;
        n = 0;
        while (o_drive_reset !== 1'b1 && n < 30) begin
            step(1);
            n++;
        end
        `CHK("rst_seen", 1'b1, o_drive_reset)
        i_drive_fault = 1'b0;
        step(12);
        `CHK("err_clr", 1'b0, o_error_status_flag)
        i_error_reset_request = 1'b0;
        {i_net_input_three, i_net_input_four, i_net_input_five} = 3'h7;
        step(6);
        `CHK("net_active", 3'h7, o_net_func_active)
        `CHK("net_code", 24'h112233, o_net_func_code)
        i_command_source_param = 1'b1;
        step(1);
        i_input_function_params[71:56] = 16'h440a;
        step(6);
        `CHK("net_resel", 8'h44, o_net_func_code[15:8])
        `CHK("net_blocked", 3'h6, o_net_func_active)
        end_sim();
    end
endmodule : rch_command_handshake_tb
